// ===== pevi_pkg.sv
package pevi_pkg;
	// Power mode codes, one-hot
	typedef enum logic [4:0] {
		PEVI_MODE_RUN = 5'b0_0001,
		PEVI_MODE_SLEEP = 5'b0_0010,
		PEVI_MODE_LPRUN = 5'b0_0100,
		PEVI_MODE_LPSLEEP = 5'b0_1000,
		PEVI_MODE_STOP = 5'b1_0000
	} pevi_mode_e;
	// Routing widths
	localparam int PEVI_NUM_GPIO = 4;
	localparam int PEVI_NUM_CLK = 4;
	localparam int PEVI_SEL_W = 2;
	// Fixed latency of the routing register stage, in mclk cycles
	localparam int PEVI_LATENCY = 1;
	// Reset values
	localparam logic PEVI_OUT_RST = 1'b0;
	localparam pevi_mode_e PEVI_MODE_RST = PEVI_MODE_RUN;
endpackage

// ===== pevi_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous event lines
module pevi_sync
	import pevi_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Lines
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q; // First stage, read only by second
	logic [W-1:0] sync_q;

	// Double flop
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule

// ===== pevi_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Hardwired peripheral paths, fixed latency, no processor
// - Comparators to timers except stop; lptimer always
// - Timer chains another timer, off in stop
// - Wakeup event triggers timer two, off in stop
// - Clock events trigger low power timer always
// - Clock sources to timer channel, off in stop
// - GPIO to timers except stop; lptimer always
module pevi_top
	import pevi_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Power mode, same clock domain
	input wire logic [4:0] power_mode_i,
	// Path selects, static configuration
	input wire logic [PEVI_SEL_W-1:0] clk_sel_i,
	input wire logic [PEVI_SEL_W-1:0] gpio_tim_sel_i,
	input wire logic [PEVI_SEL_W-1:0] gpio_lpt_sel_i,
	input wire logic [PEVI_SEL_W-1:0] gpio_adc_sel_i,
	// Event sources, asynchronous
	input wire logic comparator_a_i,
	input wire logic comparator_b_i,
	input wire logic wakeup_evt_i,
	input wire logic clock_evt_i,
	input wire logic [PEVI_NUM_CLK-1:0] clk_src_i,
	input wire logic [PEVI_NUM_GPIO-1:0] gpio_i,
	// Timer trigger outputs, same clock domain
	input wire logic general_timer_one_trgo_i,
	input wire logic general_timer_two_trgo_i,
	// Destinations, general timers
	output logic general_timer_one_cmp_o,
	output logic general_timer_two_cmp_o,
	output logic general_timer_one_itr_o,
	output logic general_timer_two_itr_o,
	output logic general_timer_two_wkup_o,
	output logic any_general_timer_clk_o,
	output logic any_general_timer_gpio_o,
	// Destinations, low power timer and converter
	output logic low_power_timer_cmp_o,
	output logic low_power_timer_evt_o,
	output logic low_power_timer_gpio_o,
	output logic adc_trig_o
);
	////////////////////////////////////////////////////////////////////
	// Synchronise asynchronous sources
	// Every pin-side source passes two flops before any routing logic.
	// That costs two cycles on every such path, but the same two on
	// all of them, so the end-to-end latency stays fixed.
	// Timer triggers and the mode come from mclk logic and skip this.
	// Source count: four single lines plus the clock and gpio buses
	localparam int NS = 4 + PEVI_NUM_CLK + PEVI_NUM_GPIO;
	logic [NS-1:0] sync_w; // Synchronised source bundle
	logic cmp_a_s; // Comparator a, synchronised
	logic cmp_b_s; // Comparator b, synchronised
	logic wkup_s; // Auto wakeup event, synchronised
	logic cevt_s; // Clock event, synchronised
	logic [PEVI_NUM_CLK-1:0] clk_s; // Clock sources, synchronised
	logic [PEVI_NUM_GPIO-1:0] gpio_s; // Gpio lines, synchronised

	pevi_sync #(.W(NS)) u_sync (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.async_i({gpio_i, clk_src_i, clock_evt_i, wakeup_evt_i,
			comparator_b_i, comparator_a_i}),
		.sync_o(sync_w)
	);
	assign {gpio_s, clk_s, cevt_s, wkup_s, cmp_b_s, cmp_a_s} = sync_w;

	////////////////////////////////////////////////////////////////////
	// Mode decode; unknown codes treated as stop for safety
	// The mode is a one-hot code from the power controller on mclk.
	// Any other pattern means the controller is between modes; gating
	// is then the safe answer, since an ungated trigger could reach a
	// timer that is about to lose its clock.
	logic active_w; // Run, sleep or low power run/sleep
	always_comb begin
		unique case (power_mode_i)
			// Four modes that keep the general timers clocked
			PEVI_MODE_RUN, PEVI_MODE_SLEEP,
			PEVI_MODE_LPRUN, PEVI_MODE_LPSLEEP: active_w = 1'b1;
			// Stop and every illegal code
			default: active_w = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Registered gated routing, one cycle after synchronisation
	// Outputs are flops so a destination never sees a mux glitch
	// when a select or the mode moves; the price is one more cycle.
	// Comparator b feeds both general timers, comparator a the lptimer.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			general_timer_one_cmp_o <= PEVI_OUT_RST;
			general_timer_two_cmp_o <= PEVI_OUT_RST;
			low_power_timer_cmp_o <= PEVI_OUT_RST;
		end else begin
			// Comparator paths
			general_timer_one_cmp_o <= cmp_b_s & active_w;
			general_timer_two_cmp_o <= cmp_b_s & active_w;
			low_power_timer_cmp_o <= cmp_a_s;
		end
	end

	// Timer chaining and clock-domain events
	// Trigger inputs are already on mclk, so they take one edge only.
	// A user chaining timers must allow for that single cycle.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			general_timer_one_itr_o <= PEVI_OUT_RST;
			general_timer_two_itr_o <= PEVI_OUT_RST;
			general_timer_two_wkup_o <= PEVI_OUT_RST;
			low_power_timer_evt_o <= PEVI_OUT_RST;
		end else begin
			// Each timer triggered by the other
			general_timer_one_itr_o <=
				general_timer_two_trgo_i & active_w;
			general_timer_two_itr_o <=
				general_timer_one_trgo_i & active_w;
			general_timer_two_wkup_o <= wkup_s & active_w;
			// Stays live in stop: used as wakeup source
			low_power_timer_evt_o <= cevt_s;
		end
	end

	// Selected clock source and GPIO paths
	// Selects are static; changing one mid-run may pass one stray
	// cycle of the newly chosen line, which is accepted behaviour.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			any_general_timer_clk_o <= PEVI_OUT_RST;
			any_general_timer_gpio_o <= PEVI_OUT_RST;
			low_power_timer_gpio_o <= PEVI_OUT_RST;
			adc_trig_o <= PEVI_OUT_RST;
		end else begin
			// Clock sampled at mclk; only slow RC clocks measure well
			any_general_timer_clk_o <= clk_s[clk_sel_i] & active_w;
			any_general_timer_gpio_o <=
				gpio_s[gpio_tim_sel_i] & active_w;
			low_power_timer_gpio_o <= gpio_s[gpio_lpt_sel_i];
			adc_trig_o <= gpio_s[gpio_adc_sel_i] & active_w;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	a_cmp_b_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!active_w |=> !general_timer_one_cmp_o && !general_timer_two_cmp_o)
		else $error("comparator b path live in stop");
	a_cmp_a_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		low_power_timer_cmp_o == $past(cmp_a_s))
		else $error("comparator a path wrong");
	a_tim_chain: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_two_itr_o == $past(general_timer_one_trgo_i & active_w))
		else $error("timer chain wrong");
	a_wkup_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_two_wkup_o |-> $past(active_w) && $past(wkup_s))
		else $error("wakeup route wrong");
	a_evt_latency: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		$rose(clock_evt_i) ##1 clock_evt_i[*2] |-> ##1 low_power_timer_evt_o)
		else $error("clock event latency wrong");
	a_clk_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		any_general_timer_clk_o |-> $past(active_w))
		else $error("clock path live in stop");
	a_gpio_lpt: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		low_power_timer_gpio_o == $past(gpio_s[gpio_lpt_sel_i]))
		else $error("gpio lptimer path wrong");
	a_adc_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		adc_trig_o == $past(gpio_s[gpio_adc_sel_i] & active_w))
		else $error("adc trigger wrong");
	a_fixed_lat: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		$past(gpio_s[gpio_tim_sel_i] & active_w) == any_general_timer_gpio_o)
		else $error("gpio timer latency wrong");

	////////////////////////////////////////////////////////////////////
	// Per-path checks, several on outputs already covered above, plus the stop decode
	// The equality checks compare against the source one edge back,
	// which pins both the routing and the register stage.

	// Comparator b into timer one, gated
	a_cmp_b_one: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_one_cmp_o == $past(cmp_b_s & active_w))
		else $error("comparator b to timer one wrong");
	// Comparator b into timer two, gated
	a_cmp_b_two: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_two_cmp_o == $past(cmp_b_s & active_w))
		else $error("comparator b to timer two wrong");
	// Stop code must always close the gated paths
	a_stop_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		power_mode_i == PEVI_MODE_STOP |-> !active_w)
		else $error("stop mode not decoded");
	// Timer two trigger into timer one, gated
	a_chain_back: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_one_itr_o == $past(general_timer_two_trgo_i & active_w))
		else $error("reverse timer chain wrong");
	// Wakeup event follows its source in the four live modes
	a_wkup_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		general_timer_two_wkup_o == $past(wkup_s & active_w))
		else $error("wakeup route value wrong");
	// Clock event never gated, fixed register latency
	a_evt_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		low_power_timer_evt_o == $past(cevt_s, PEVI_LATENCY))
		else $error("clock event route wrong");
	// Selected clock source follows its select
	a_clk_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		any_general_timer_clk_o == $past(clk_s[clk_sel_i] & active_w))
		else $error("clock source route wrong");
	// Gpio to general timers dark one edge after leaving live modes
	a_gpio_stop: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!active_w |=> !any_general_timer_gpio_o)
		else $error("gpio timer path live in stop");
	// Converter trigger dark one edge after leaving live modes
	a_adc_stop: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		!active_w |=> !adc_trig_o)
		else $error("adc trigger live in stop");
endmodule

// ===== pevi_peer.sv
`timescale 1ns/1ps
// Timer pair model: trigger outputs launched on the clock
module pevi_peer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Fire requests, bit 0 timer one, bit 1 timer two
	input wire logic [1:0] fire_i,
	// Trigger outputs
	output logic [1:0] trgo_o
);
	// Registered like a real timer trigger, so it costs one edge
	always_ff @(posedge mclk_i) begin
		trgo_o <= reset_n_i ? fire_i : 2'h0;
	end
endmodule

// ===== test_peripheral_event_interconnect.sv
`timescale 1ns/1ps
// Bench for the event interconnect
module test_peripheral_event_interconnect
	import pevi_pkg::*;
;
	logic mclk_i, reset_n_i, ca, cb, wk, ce; // Clock, reset, sources
	logic [4:0] md; // Power mode
	logic [1:0] cs, ts, ls, as, fire, trgo; // Selects, timer triggers
	logic [3:0] csrc, gp; // Clock sources, gpio
	logic [10:0] got; // All destinations, packed
	int error_cnt, num_checks;
	pevi_top u_pevi_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.power_mode_i(md), .clk_sel_i(cs), .gpio_tim_sel_i(ts),
		.gpio_lpt_sel_i(ls), .gpio_adc_sel_i(as), .comparator_a_i(ca),
		.comparator_b_i(cb), .wakeup_evt_i(wk), .clock_evt_i(ce),
		.clk_src_i(csrc), .gpio_i(gp), .general_timer_one_trgo_i(trgo[0]),
		.general_timer_two_trgo_i(trgo[1]),
		.general_timer_one_cmp_o(got[10]), .general_timer_two_cmp_o(got[9]),
		.general_timer_one_itr_o(got[8]), .general_timer_two_itr_o(got[7]),
		.general_timer_two_wkup_o(got[6]), .any_general_timer_clk_o(got[5]),
		.any_general_timer_gpio_o(got[4]), .low_power_timer_cmp_o(got[3]),
		.low_power_timer_evt_o(got[2]), .low_power_timer_gpio_o(got[1]),
		.adc_trig_o(got[0]));
	pevi_peer u_pevi_peer (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.fire_i(fire), .trgo_o(trgo));
	////////////////////////////////////////////////////////////////////
	// Expected map; unknown codes count as stop, so gated paths drop
	function automatic logic [10:0] ev(input logic [4:0] m);
		logic a;
		a = m inside {PEVI_MODE_RUN, PEVI_MODE_SLEEP, PEVI_MODE_LPRUN,
			PEVI_MODE_LPSLEEP};
		return {a & cb, a & cb, a & trgo[1], a & trgo[0], a & wk,
			a & csrc[cs], a & gp[ts], ca, ce, gp[ls], a & gp[as]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [10:0] e);
		num_checks++;
		if (got !== e) begin
			$display("BAD %s exp %h got %h", nm, e, got);
			error_cnt++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Every mode, sources swapped high and low to catch crossed paths
	task automatic t_modes();
		logic [4:0] c [6];
		c = '{PEVI_MODE_RUN, PEVI_MODE_SLEEP, PEVI_MODE_LPRUN,
			PEVI_MODE_LPSLEEP, PEVI_MODE_STOP, 5'h00};
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk_i);
			md <= c[i/2];
			ca <= i[0];
			cb <= !i[0];
			wk <= i[0];
			ce <= !i[0];
			csrc <= i[0] ? 4'hF : 4'h0;
			gp <= i[0] ? 4'h0 : 4'hF;
			fire <= i[0] ? 2'h1 : 2'h2;
			tick(4);
			chk("modes", ev(c[i/2]));
		end
		$display("done modes");
	endtask
	// Each select index picks only its own line
	task automatic t_sel();
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_i);
			md <= PEVI_MODE_RUN;
			{cs, ts, as} <= {3{i[1:0]}};
			ls <= 2'h3 - i[1:0];
			csrc <= 4'h1 << i;
			gp <= 4'h1 << i;
			tick(4);
			chk("sel", ev(PEVI_MODE_RUN));
		end
		$display("done sel");
	endtask
	// Fixed latency: three edges async, one edge same domain and mode
	task automatic t_lat();
		@(posedge mclk_i);
		{ts, ls, as, gp, fire} <= 0;
		tick(4);
		@(posedge mclk_i);
		gp <= 4'h1;
		tick(2);
		chk("lat2", ev(md) & ~11'h013);
		tick(1);
		chk("lat3", ev(md));
		@(posedge mclk_i);
		fire <= 2'h3;
		tick(1);
		chk("trg1", ev(md) & ~11'h180);
		tick(1);
		chk("trg2", ev(md));
		@(posedge mclk_i);
		md <= PEVI_MODE_STOP;
		tick(1);
		chk("stop", ev(PEVI_MODE_STOP));
		$display("done lat");
	endtask
	initial begin
		mclk_i = 0;
		forever #2 mclk_i = ~mclk_i;
	end
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
	initial begin
		{reset_n_i, wk, cb, csrc, gp, cs, ts, ls, as, fire} = 0;
		{ca, ce} = 2'h3;
		md = PEVI_MODE_RUN;
		tick(12);
		chk("reset", 11'h000);
		@(posedge mclk_i);
		reset_n_i <= 1'b1;
		t_modes();
		t_sel();
		t_lat();
		end_sim();
	end
endmodule
